// ---- hdl/icgen_ctrl.sv ----
// control logic of the on-chip clock generator
// assumes ext_ref_i and osc_ok_i are asynchronous pin-level inputs
// Behaviour
// - after reset the generator runs self-clocked without a reference
// - loop output programmable from 8 to 40 MHz, bus up to 20 MHz
// - post-loop divider picks one of eight factors, /1 to /128
// - a clock source that is not running cannot be selected
// - loss of reference or lock raises reset or interrupt per config
// - oscillator keeps its setting to relock fast after stop
// - oscillator holds its frequency while the reference is gone
// - system clock moves to loop output by itself once locked
// - flags show lock achieved and later loss of lock
// - external reference is monitored and its validity reported
// - low range 32 to 100 kHz, high range 1 to 16 MHz, by software
// - external square wave can pass straight to the system clock
// - high gain select chooses low power or high amplitude
// - 8 MHz internal reference selectable as debug local clock
// - 243 kHz internal reference trimmable by software
// - loop takes internal or external reference and multiplies it
// - loop clock and raw external clock are separate outputs
// - selector drives the fixed frequency enable
// - slow internal reference tick also feeds the real-time interrupt
// - self-clocked mode runs open loop at the filter value
// - off mode holds the output clock static
// - range sets prescale 64 low or 1 high, external modes only
`timescale 1ns/1ps
`include "icgen_defs.svh"
module icgen_ctrl #(
  parameter int REF_TIMEOUT = `ICGEN_REF_TIMEOUT_CYC
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  cfg_write_i,
  input  wire icgen_pkg::icgen_cfg_s cfg_i,
  input  wire icgen_pkg::icgen_mode_e mode_req_i,
  input  wire logic                  stop_i,
  input  wire logic                  ext_ref_i,
  input  wire logic                  osc_ok_i,
  input  wire logic                  slow_ref_tick_i,
  input  wire logic                  fast_ref_tick_i,
  input  wire logic                  dco_tick_i,
  input  wire logic [7:0]            trim_i,
  input  wire logic                  trim_write_i,
  input  wire logic                  debug_fast_sel_i,
  input  wire logic                  flag_clear_i,
  output icgen_pkg::icgen_mode_e     mode_o,
  output icgen_pkg::icgen_status_s   status_o,
  output logic [11:0]                dco_filter_o,
  output logic [7:0]                 internal_reference_trim_o,
  output logic                       high_gain_select_o,
  output logic                       range_high_o,
  output logic [6:0]                 prescale_o,
  output logic                       loop_multiplied_clock_en_o,
  output logic                       external_reference_clock_out_en_o,
  output logic                       generator_output_clock_en_o,
  output logic                       bus_clock_tick_o,
  output logic                       fixed_frequency_enable_o,
  output logic                       debug_local_clock_fast_o,
  output logic                       rti_clock_tick_o,
  output logic                       loss_reset_o,
  output logic                       loss_irq_o
);
  initial begin
    if (REF_TIMEOUT < 2) $error("reference timeout too short");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ext_sync;
  logic [1:0] osc_sync;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext_sync <= 2'b00;
      osc_sync <= 2'b00;
    end else begin
      ext_sync <= {ext_sync[0], ext_ref_i};
      osc_sync <= {osc_sync[0], osc_ok_i};
    end
  end

  // ****************************************
  // write-once configuration, divider, multiplier and loss routing rewritable
  // ****************************************
  icgen_pkg::icgen_cfg_s cfg;
  logic                  cfg_done;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg      <= '0;
      cfg_done <= 1'b0;
    end else if (cfg_write_i) begin
      cfg_done <= 1'b1;
      if (!cfg_done) begin
        cfg <= cfg_i;
      end else begin
        cfg.post_div_sel <= cfg_i.post_div_sel;
        cfg.mult         <= cfg_i.mult;
        cfg.loss_resets  <= cfg_i.loss_resets;
      end
    end
  end
  assign high_gain_select_o = cfg.high_gain_select;
  assign range_high_o       = cfg.range_high;

  // ****************************************
  // reference monitor
  // ****************************************
  logic ext_mode;
  logic ref_valid;
  logic ref_edge;
  icgen_ref_monitor #(
    .TIMEOUT (REF_TIMEOUT)
  ) u_mon (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .enable_i (ext_mode),
    .ref_i    (ext_sync[1]),
    .valid_o  (ref_valid),
    .edge_o   (ref_edge)
  );
  // oscillator must also report running when crystal mode
  logic ext_running;
  assign ext_running = ref_valid & (osc_sync[1] | ~cfg.ref_is_osc);

  // ****************************************
  // mode state machine
  // ****************************************
  icgen_pkg::icgen_mode_e mode;
  icgen_pkg::icgen_mode_e next_mode;
  icgen_pkg::icgen_mode_e run_mode;
  always_comb begin
    next_mode = mode;
    case (mode_req_i)
      icgen_pkg::ICGEN_EXT_BYPASS,
      icgen_pkg::ICGEN_EXT_LOOP:
        next_mode = ext_running ? mode_req_i : icgen_pkg::ICGEN_SELF;
      icgen_pkg::ICGEN_INT_LOOP: next_mode = icgen_pkg::ICGEN_INT_LOOP;
      default:                   next_mode = icgen_pkg::ICGEN_SELF;
    endcase
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode     <= icgen_pkg::ICGEN_SELF;
      run_mode <= icgen_pkg::ICGEN_SELF;
    end else if (stop_i) begin
      mode <= icgen_pkg::ICGEN_OFF;
    end else begin
      mode     <= next_mode;
      run_mode <= next_mode;
    end
  end
  assign mode_o   = mode;
  assign ext_mode = (mode_req_i == icgen_pkg::ICGEN_EXT_BYPASS)
                  | (mode_req_i == icgen_pkg::ICGEN_EXT_LOOP);

  logic loop_mode;
  logic ext_loop;
  assign ext_loop  = (mode == icgen_pkg::ICGEN_EXT_LOOP);
  assign loop_mode = ext_loop | (mode == icgen_pkg::ICGEN_INT_LOOP);
  assign prescale_o = (ext_loop | mode == icgen_pkg::ICGEN_EXT_BYPASS) &
                      ~cfg.range_high ? 7'(`ICGEN_PRESCALE_LOW)
                                      : 7'(`ICGEN_PRESCALE_HIGH);

  // ****************************************
  // frequency-locked loop
  // ****************************************
  logic        ref_tick;
  logic [11:0] dco_count;
  logic [11:0] target;
  logic [11:0] filter;
  logic [3:0]  good_run;
  logic        locked;
  logic        err_small;
  assign ref_tick = ext_loop ? ref_edge : slow_ref_tick_i;
  assign target   = 12'({5'h00, cfg.mult} * 12'(prescale_o));
  assign err_small = (dco_count + `ICGEN_LOCK_TOL >= target) &&
                     (dco_count <= target + `ICGEN_LOCK_TOL);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dco_count <= 12'h000;
      filter    <= `ICGEN_FILTER_RESET;
      good_run  <= 4'h0;
      locked    <= 1'b0;
    end else if (!loop_mode || ext_loop && !ref_valid) begin
      dco_count <= 12'h000;         // filter untouched
      good_run  <= 4'h0;
      locked    <= 1'b0;
    end else if (ref_tick) begin
      dco_count <= 12'h000;
      if (dco_count < target) begin
        filter <= filter + 12'h001;
      end else if (dco_count > target) begin
        filter <= filter - 12'h001;
      end
      if (!err_small) begin
        good_run <= 4'h0;
        locked   <= 1'b0;
      end else if (good_run >= `ICGEN_LOCK_COUNT) begin
        locked <= 1'b1;
      end else begin
        good_run <= good_run + 4'h1;
      end
    end else if (dco_tick_i) begin
      dco_count <= dco_count + 12'h001;
    end
  end
  assign dco_filter_o = filter;

  // ****************************************
  // status flags, set beats clear
  // ****************************************
  logic on_loop;
  logic locked_d;
  logic valid_d;
  logic lost_lock;
  logic lost_ref;
  logic lock_fall;
  logic ref_fall;
  assign lock_fall = locked_d & ~locked & loop_mode;
  assign ref_fall  = valid_d & ~ref_valid & ext_mode;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      locked_d  <= 1'b0;
      valid_d   <= 1'b0;
      lost_lock <= 1'b0;
      lost_ref  <= 1'b0;
    end else begin
      locked_d  <= locked;
      valid_d   <= ref_valid;
      lost_lock <= lock_fall | (lost_lock & ~flag_clear_i);
      lost_ref  <= ref_fall | (lost_ref & ~flag_clear_i);
    end
  end
  assign status_o = '{locked:    locked,
                      lost_lock: lost_lock,
                      ref_valid: ext_running,
                      lost_ref:  lost_ref,
                      on_loop:   on_loop};
  assign loss_reset_o = (lost_lock | lost_ref) & cfg.loss_resets;
  assign loss_irq_o   = (lost_lock | lost_ref) & ~cfg.loss_resets;

  // ****************************************
  // clock selection, switched at divider wrap
  // ****************************************
  logic div_tick;
  logic running;
  assign running = (mode != icgen_pkg::ICGEN_OFF);
  icgen_post_div u_div (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (running),
    .sel_i   (cfg.post_div_sel),
    .tick_o  (div_tick)
  );
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      on_loop <= 1'b0;
    end else if (div_tick) begin
      on_loop <= loop_mode & locked;
    end
  end
  assign loop_multiplied_clock_en_o        = on_loop;
  assign external_reference_clock_out_en_o = ext_running;
  assign generator_output_clock_en_o       = running;
  assign bus_clock_tick_o                  = div_tick;
  assign fixed_frequency_enable_o = running &
         (mode == icgen_pkg::ICGEN_EXT_BYPASS | (ext_loop & on_loop));
  assign debug_local_clock_fast_o = debug_fast_sel_i;
  assign rti_clock_tick_o         = fast_ref_tick_i & 1'b0 | slow_ref_tick_i;

  // ****************************************
  // internal reference trim
  // ****************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      internal_reference_trim_o <= `ICGEN_TRIM_RESET;
    end else if (trim_write_i) begin
      internal_reference_trim_o <= trim_i;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_stop;
    stop_i;
  endsequence
  property p_off_static;
    @(posedge clock_i) disable iff (rst_i)
      s_stop |=> !generator_output_clock_en_o;
  endproperty
  a_off_static: assert property (p_off_static)
    else $error("output clock not static in off mode");
  property p_lockout;
    @(posedge clock_i) disable iff (rst_i)
      !ext_running && !stop_i |=> mode != icgen_pkg::ICGEN_EXT_LOOP ||
                                  $past(mode) == icgen_pkg::ICGEN_EXT_LOOP;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("dead source selected");
  property p_loss_route;
    @(posedge clock_i) disable iff (rst_i)
      (lost_lock || lost_ref) |-> (loss_reset_o ^ loss_irq_o);
  endproperty
  a_loss_route: assert property (p_loss_route)
    else $error("loss not routed to exactly one output");
  property p_hold_filter;
    @(posedge clock_i) disable iff (rst_i)
      !loop_mode ##1 !loop_mode |-> $stable(dco_filter_o);
  endproperty
  a_hold_filter: assert property (p_hold_filter)
    else $error("filter moved while open loop");
  property p_auto_engage;
    @(posedge clock_i) disable iff (rst_i)
      (loop_mode && locked && !stop_i) [*2] ##0 div_tick |=> on_loop;
  endproperty
  a_auto_engage: assert property (p_auto_engage)
    else $error("loop not engaged after lock");
  property p_lost_sticky;
    @(posedge clock_i) disable iff (rst_i)
      lock_fall |=> lost_lock;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky)
    else $error("lock loss not flagged");
  property p_prescale;
    @(posedge clock_i) disable iff (rst_i)
      mode == icgen_pkg::ICGEN_INT_LOOP |-> prescale_o == 7'h01;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescale applied outside external modes");
  property p_reset_self;
    @(posedge clock_i) $fell(rst_i) |-> mode == icgen_pkg::ICGEN_SELF;
  endproperty
  a_reset_self: assert property (p_reset_self)
    else $error("not self clocked after reset");
  property p_no_runt;
    @(posedge clock_i) disable iff (rst_i)
      $changed(on_loop) |-> $past(div_tick);
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("source switched mid period");
endmodule : icgen_ctrl

// ---- hdl/icgen_defs.svh ----
// constants for the internal clock generator control logic
// assumes inclusion by bare name from the design and bench files
`ifndef ICGEN_DEFS_SVH
`define ICGEN_DEFS_SVH

// ****************************************
// loop range and divider
// ****************************************
`define ICGEN_LOOP_MIN_KHZ     8000
`define ICGEN_LOOP_MAX_KHZ     40000
`define ICGEN_BUS_MAX_KHZ      20000
`define ICGEN_POSTDIV_CODES    8
`define ICGEN_POSTDIV_MAX      128
`define ICGEN_PRESCALE_LOW     64
`define ICGEN_PRESCALE_HIGH    1

// ****************************************
// reference ranges in kHz
// ****************************************
`define ICGEN_LOW_MIN_KHZ      32
`define ICGEN_LOW_MAX_KHZ      100
`define ICGEN_HIGH_MIN_KHZ     1000
`define ICGEN_HIGH_MAX_KHZ     16000

// ****************************************
// internal references and reset values
// ****************************************
`define ICGEN_DEBUG_REF_KHZ    8000
`define ICGEN_SLOW_REF_KHZ     243
`define ICGEN_TRIM_RESET       8'h80
`define ICGEN_FILTER_RESET     12'h200
`define ICGEN_TRIM_NVM_ADDR    16'hFFBE

// ****************************************
// timing counts
// ****************************************
`define ICGEN_CLK_PERIOD_NS    10
`define ICGEN_REF_TIMEOUT_NS   2560
`define ICGEN_REF_TIMEOUT_CYC  (`ICGEN_REF_TIMEOUT_NS / `ICGEN_CLK_PERIOD_NS)
`define ICGEN_LOCK_TOL         12'h004
`define ICGEN_LOCK_COUNT       4'h8

`endif

// ---- hdl/icgen_pkg.sv ----
// types shared by the clock generator control logic
// assumes icgen_defs.svh for the numeric constants
package icgen_pkg;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [2:0] {
    ICGEN_OFF,
    ICGEN_SELF,
    ICGEN_INT_LOOP,
    ICGEN_EXT_BYPASS,
    ICGEN_EXT_LOOP
  } icgen_mode_e;

  // ****************************************
  // configuration and status bundles
  // ****************************************
  typedef struct packed {
    logic        high_gain_select;
    logic        range_high;
    logic        ref_is_osc;
    logic        loss_resets;
    logic [2:0]  post_div_sel;
    logic [6:0]  mult;
  } icgen_cfg_s;

  typedef struct packed {
    logic        locked;
    logic        lost_lock;
    logic        ref_valid;
    logic        lost_ref;
    logic        on_loop;
  } icgen_status_s;

endpackage : icgen_pkg

// ---- hdl/icgen_ref_monitor.sv ----
// watches a pin-level reference clock for activity
// assumes ref_i already passed two flip-flops in the parent
`timescale 1ns/1ps
`include "icgen_defs.svh"
module icgen_ref_monitor #(
  parameter int TIMEOUT = `ICGEN_REF_TIMEOUT_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic ref_i,
  output logic      valid_o,
  output logic      edge_o
);
  initial begin
    if (TIMEOUT < 2) $error("timeout too short");
  end

  logic        ref_d;
  logic [15:0] idle;
  logic        rise;
  assign rise = ref_i & ~ref_d;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ref_d   <= 1'b0;
      idle    <= 16'h0000;
      valid_o <= 1'b0;
      edge_o  <= 1'b0;
    end else begin
      ref_d  <= ref_i;
      edge_o <= rise & enable_i;
      if (!enable_i) begin
        idle    <= 16'h0000;
        valid_o <= 1'b0;
      end else if (rise) begin
        idle    <= 16'h0000;
        valid_o <= 1'b1;
      end else if (idle >= 16'(TIMEOUT)) begin
        valid_o <= 1'b0;
      end else begin
        idle <= idle + 16'h0001;
      end
    end
  end
endmodule : icgen_ref_monitor

// ---- hdl/icgen_post_div.sv ----
// power-of-two divider with glitch-free select changes
// assumes sel_i may change at any time; new ratio taken at wrap
`timescale 1ns/1ps
`include "icgen_defs.svh"
module icgen_post_div #(
  parameter int CODES = `ICGEN_POSTDIV_CODES
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);
  initial begin
    if (CODES != 8) $error("divider needs eight codes");
  end

  logic [6:0] cnt;
  logic [2:0] sel_hold;
  logic [6:0] limit;
  assign limit = 7'((8'h01 << sel_hold) - 8'h01);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt      <= 7'h00;
      sel_hold <= 3'h0;
      tick_o   <= 1'b0;
    end else if (run_i) begin
      if (cnt >= limit) begin
        cnt      <= 7'h00;
        sel_hold <= sel_i;
        tick_o   <= 1'b1;
      end else begin
        cnt    <= cnt + 7'h01;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule : icgen_post_div

// ---- test/icgen_ext_src.sv ----
// behavioural external reference: crystal, resonator or square wave
// assumes run_i from the bench; phase unrelated to the system clock
`timescale 1ns/1ps
module icgen_ext_src #(
  parameter int HALF_NS = 23
) (
  input  wire logic run_i,
  output logic      ext_ref_o,
  output logic      osc_ok_o
);
  // ****************************************
  // reference clock
  // ****************************************
  initial ext_ref_o = 1'b0;
  // free-running square wave, stands still while stopped
  always begin
    #(HALF_NS);
    if (run_i) ext_ref_o = ~ext_ref_o;
  end
  // oscillator-running indication follows the source
  assign osc_ok_o = run_i;
endmodule : icgen_ext_src

// ---- test/tb_internal_clock_generator.sv ----
// self-checking bench for the clock generator control logic
// assumes icgen_ctrl with a short reference timeout of 8 cycles
`timescale 1ns/1ps
`include "icgen_defs.svh"
module tb_internal_clock_generator;
  // ****************************************
  // signals
  // ****************************************
  logic clock_i = 1'b0, rst_i = 1'b1, cfg_write_i = 1'b0, stop_i = 1'b0;
  logic slow_ref_tick_i = 1'b0, fast_ref_tick_i = 1'b0, dco_tick_i = 1'b1;
  logic trim_write_i = 1'b0, debug_fast_sel_i = 1'b0, flag_clear_i = 1'b0;
  logic run = 1'b0, ext_ref, osc_ok;
  logic [7:0] trim_i = 8'h00;
  logic [1:0] fdiv = 2'h0;
  logic [11:0] filt;
  icgen_pkg::icgen_cfg_s cfg_i = '0;
  icgen_pkg::icgen_mode_e mode_req_i = icgen_pkg::ICGEN_SELF, mode_o;
  icgen_pkg::icgen_status_s status_o;
  logic [11:0] dco_filter_o;
  logic [7:0] internal_reference_trim_o;
  logic [6:0] prescale_o;
  logic hgs_o, rng_o, ldclk_o, fixed_frequency_clock_o, gen_o, bus_o, ffe_o, dbg_o, rti_o;
  logic lrst_o, lirq_o;
  int failures = 0, check_count = 0, cycles = 0, n;
  always #5 clock_i = ~clock_i;
  // ****************************************
  // design and partner
  // ****************************************
  icgen_ctrl #(.REF_TIMEOUT(8)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .cfg_write_i(cfg_write_i),
    .cfg_i(cfg_i), .mode_req_i(mode_req_i), .stop_i(stop_i),
    .ext_ref_i(ext_ref), .osc_ok_i(osc_ok),
    .slow_ref_tick_i(slow_ref_tick_i), .fast_ref_tick_i(fast_ref_tick_i),
    .dco_tick_i(dco_tick_i), .trim_i(trim_i), .trim_write_i(trim_write_i),
    .debug_fast_sel_i(debug_fast_sel_i), .flag_clear_i(flag_clear_i),
    .mode_o(mode_o), .status_o(status_o), .dco_filter_o(dco_filter_o),
    .internal_reference_trim_o(internal_reference_trim_o),
    .high_gain_select_o(hgs_o), .range_high_o(rng_o),
    .prescale_o(prescale_o), .loop_multiplied_clock_en_o(ldclk_o),
    .external_reference_clock_out_en_o(fixed_frequency_clock_o),
    .generator_output_clock_en_o(gen_o), .bus_clock_tick_o(bus_o),
    .fixed_frequency_enable_o(ffe_o), .debug_local_clock_fast_o(dbg_o),
    .rti_clock_tick_o(rti_o), .loss_reset_o(lrst_o), .loss_irq_o(lirq_o));
  icgen_ext_src #(.HALF_NS(23)) u_src (
    .run_i(run), .ext_ref_o(ext_ref), .osc_ok_o(osc_ok));
  // fast internal reference ticks every fourth cycle
  always @(posedge clock_i) begin
    fdiv <= fdiv + 2'h1;
    fast_ref_tick_i <= (fdiv == 2'h3);
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic do_reset();
    rst_i <= 1'b1;
    tick(1);
    @(posedge clock_i) rst_i <= 1'b0;
    #1;
  endtask : do_reset
  task automatic write_cfg(input logic hg, input logic rh, input logic osc,
                           input logic [2:0] pd);
    @(posedge clock_i);
    cfg_i <= '{hg, rh, osc, 1'b0, pd, 7'h10};
    cfg_write_i <= 1'b1;
    @(posedge clock_i) cfg_write_i <= 1'b0;
    #1;
  endtask : write_cfg
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    do_reset();
    chk(16'(mode_o), 16'(icgen_pkg::ICGEN_SELF));
    chk(16'(dco_filter_o), 16'h0200);
    chk(16'(internal_reference_trim_o), 16'h0080);
    chk(16'(gen_o), 16'h0001);
    chk(16'(status_o.locked), 16'h0000);
    @(posedge clock_i);
    trim_i <= 8'h5A; // trim as reloaded from the saved slot
    trim_write_i <= 1'b1;
    debug_fast_sel_i <= 1'b1;
    slow_ref_tick_i <= 1'b1;
    #1;
    chk(16'(rti_o), 16'h0001);
    chk(16'(dbg_o), 16'h0001);
    @(posedge clock_i);
    trim_write_i <= 1'b0;
    slow_ref_tick_i <= 1'b0;
    debug_fast_sel_i <= 1'b0;
    #1;
    chk(16'(internal_reference_trim_o), 16'h005A);
    chk(16'(rti_o), 16'h0000);
    chk(16'(dbg_o), 16'h0000);
    // dead source: external loop request refused
    write_cfg(1'b1, 1'b0, 1'b1, 3'h0);
    mode_req_i <= icgen_pkg::ICGEN_EXT_LOOP;
    tick(20);
    chk(16'(mode_o), 16'(icgen_pkg::ICGEN_SELF));
    chk(16'(hgs_o), 16'h0001);
    write_cfg(1'b0, 1'b1, 1'b0, 3'h0);
    chk(16'(hgs_o), 16'h0001);
    chk(16'(rng_o), 16'h0000);
    // source starts: reference becomes valid, external loop mode entered
    run <= 1'b1;
    for (n = 0; n < 60 && status_o.ref_valid !== 1'b1; n++) tick(1);
    chk(16'(status_o.ref_valid), 16'h0001);
    for (n = 0; n < 20 && mode_o !== icgen_pkg::ICGEN_EXT_LOOP; n++) tick(1);
    chk(16'(mode_o), 16'(icgen_pkg::ICGEN_EXT_LOOP));
    chk(16'(prescale_o), 16'(`ICGEN_PRESCALE_LOW));
    // source lost: flag, interrupt, oscillator held
    run <= 1'b0;
    for (n = 0; n < 60 && status_o.lost_ref !== 1'b1; n++) tick(1);
    filt = dco_filter_o;
    chk(16'(status_o.lost_ref), 16'h0001);
    chk(16'(status_o.ref_valid), 16'h0000);
    chk(16'(lirq_o), 16'h0001);
    chk(16'(lrst_o), 16'h0000);
    tick(10);
    chk(16'(dco_filter_o), 16'(filt));
    mode_req_i <= icgen_pkg::ICGEN_SELF;
    flag_clear_i <= 1'b1;
    tick(1);
    flag_clear_i <= 1'b0;
    tick(2);
    chk(16'(status_o.lost_ref), 16'h0000);
    // stop mode holds the output clock
    stop_i <= 1'b1;
    tick(3);
    chk(16'(mode_o), 16'(icgen_pkg::ICGEN_OFF));
    chk(16'(gen_o), 16'h0000);
    stop_i <= 1'b0;
    do_reset();
    // post divider: every factor measured between bus ticks
    for (int s = 0; s < 8; s++) begin
      write_cfg(1'b0, 1'b1, 1'b0, 3'(s));
      tick(300);
      for (n = 0; n < 300 && bus_o !== 1'b1; n++) tick(1);
      n = 0;
      do begin
        tick(1);
        n++;
      end while (bus_o !== 1'b1 && n < 300);
      chk(16'(n), 16'(1 << s));
    end
    // internal loop: 17-cycle reference locks to mult 16, then engages
    mode_req_i <= icgen_pkg::ICGEN_INT_LOOP;
    for (int k = 0; k < 12; k++) begin
      slow_ref_tick_i <= 1'b1;
      tick(1);
      slow_ref_tick_i <= 1'b0;
      tick(16);
    end
    chk(16'(status_o.locked), 16'h0001);
    for (n = 0; n < 140 && ldclk_o !== 1'b1; n++) tick(1);
    chk(16'(ldclk_o), 16'h0001);
    chk(16'(status_o.on_loop), 16'h0001);
    chk(16'(ffe_o), 16'h0000);
    chk(16'(prescale_o), 16'(`ICGEN_PRESCALE_HIGH));
    // late reference tick: lock lost, flag and interrupt raised
    tick(40);
    slow_ref_tick_i <= 1'b1;
    tick(1);
    slow_ref_tick_i <= 1'b0;
    tick(2);
    chk(16'(status_o.lost_lock), 16'h0001);
    chk(16'(lirq_o), 16'h0001);
    // external square wave bypass, high range
    run <= 1'b1;
    mode_req_i <= icgen_pkg::ICGEN_EXT_BYPASS;
    for (n = 0; n < 80 && mode_o !== icgen_pkg::ICGEN_EXT_BYPASS; n++)
      tick(1);
    chk(16'(mode_o), 16'(icgen_pkg::ICGEN_EXT_BYPASS));
    chk(16'(fixed_frequency_clock_o), 16'h0001);
    chk(16'(ffe_o), 16'h0001);
    chk(16'(prescale_o), 16'(`ICGEN_PRESCALE_HIGH));
    chk(16'(rng_o), 16'h0001);
    conclude();
  end
endmodule : tb_internal_clock_generator
